// ### src/ext_bus_ready_wait_control.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Ready polarity is selectable; high or low level may mean ready.
// - Synchronous mode samples ready directly on bus clock steps, no synchroniser.
// - Asynchronous mode passes ready through a synchroniser, costing one extra waitstate.
// - First ready sample point follows the cycle's programmed phase lengths.
// - Ready sampled inactive inserts one waitstate, then samples again.
// - Ready sampled active ends the cycle and enters the closing phase.
// - Asynchronous sample point is one bus clock later than the synchronous one.
// - Mandatory waitstates complete first; ready is ignored during them.
// - Read data captured on the edge that raises the read strobe.
module ext_bus_ready_wait_control #(
	parameter int DATA_W = ready_wait_pkg::DATA_W_DEF,
	parameter int CNT_W = ready_wait_pkg::CNT_W_DEF
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic cycle_start,
	input wire logic cycle_write,
	input wire logic [CNT_W-1:0] addr_phase_len,
	input wire logic [CNT_W-1:0] mandatory_wait_phase,
	input wire logic [CNT_W-1:0] hold_phase_len,
	input wire logic ready_enable,
	input wire logic ready_async,
	input wire logic ready_active_high,
	input wire logic ready_in,
	input wire logic [DATA_W-1:0] read_data_in,
	output logic bus_reference_clock_out,
	output logic read_strobe_n,
	output logic write_strobe_n,
	output logic address_valid,
	output logic cycle_busy,
	output logic cycle_done,
	output logic [CNT_W-1:0] ready_wait_phase,
	output logic [DATA_W-1:0] read_data
);
	// Counters must hold at least a one-clock phase; data path must be non-empty
	initial begin
		if (CNT_W < 2 || CNT_W > 16 || DATA_W < 1) begin
			$error("ext_bus_ready_wait_control: unsupported parameter values");
		end
	end

	typedef struct packed {
		ready_wait_pkg::bus_state_t st;
		logic ref_clk;
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] waits;
		logic [CNT_W-1:0] mand_len;
		logic [CNT_W-1:0] hold_len;
		logic rdy_en;
		logic rdy_async;
		logic rdy_pol;
		logic is_write;
		logic sync1;
		logic sync2;
		logic rd_n;
		logic wr_n;
		logic addr_v;
		logic busy;
		logic done;
		logic [DATA_W-1:0] rdata;
	} ctl_state_t;

	localparam logic [CNT_W-1:0] CNT_ZERO = '0;
	localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

	ctl_state_t cur;
	ctl_state_t next_cur;
	logic tick;

	// Maps the pin level onto "ready" for the selected polarity
	function automatic logic ready_is_active(input logic level, input logic active_high);
		return level ~^ active_high;
	endfunction

	// Bus steps happen on the system clock whose edge ends the reference clock's high half
	assign tick = cur.ref_clk;

	always_comb begin
		next_cur = cur;
		next_cur.done = 1'b0;
		// Reference clock runs free so the external circuit can time its ready
		next_cur.ref_clk = ~cur.ref_clk;
		if (tick) begin
			// Two-stage synchroniser on bus clock steps; only stage two is looked at
			next_cur.sync1 = ready_in;
			next_cur.sync2 = cur.sync1;
			case (cur.st)
				ready_wait_pkg::ST_IDLE: begin
					if (cycle_start) begin
						// Phase programme is latched so each cycle keeps its own sample point
						next_cur.st = ready_wait_pkg::ST_ADDR;
						next_cur.cnt = addr_phase_len;
						next_cur.mand_len = mandatory_wait_phase;
						next_cur.hold_len = hold_phase_len;
						next_cur.rdy_en = ready_enable;
						next_cur.rdy_async = ready_async;
						next_cur.rdy_pol = ready_active_high;
						next_cur.is_write = cycle_write;
						next_cur.waits = CNT_ZERO;
						next_cur.addr_v = 1'b1;
						next_cur.busy = 1'b1;
					end
				end
				ready_wait_pkg::ST_ADDR: begin
					if (cur.cnt == CNT_ZERO) begin
						next_cur.st = ready_wait_pkg::ST_CMD;
						next_cur.cnt = cur.mand_len;
						next_cur.rd_n = cur.is_write;
						next_cur.wr_n = ~cur.is_write;
					end else begin
						next_cur.cnt = cur.cnt - CNT_ONE;
					end
				end
				ready_wait_pkg::ST_CMD: begin
					// Ready level is not looked at while mandatory waits run
					if (cur.cnt != CNT_ZERO) begin
						next_cur.cnt = cur.cnt - CNT_ONE;
					end else if (!cur.rdy_en) begin
						// Fixed-length cycle: ready pin plays no part
						next_cur.st = ready_wait_pkg::ST_HOLD;
					end else if (cur.rdy_async) begin
						// Sample point moves one bus clock later for the synchroniser
						next_cur.st = ready_wait_pkg::ST_SYNC;
					end else if (ready_is_active(ready_in, cur.rdy_pol)) begin
						// Synchronous ready needs no waitstate at all
						next_cur.st = ready_wait_pkg::ST_HOLD;
					end else begin
						next_cur.st = ready_wait_pkg::ST_RDY;
						next_cur.waits = cur.waits + CNT_ONE;
					end
				end
				ready_wait_pkg::ST_SYNC: begin
					// The minimum asynchronous waitstate
					next_cur.st = ready_wait_pkg::ST_RDY;
					next_cur.waits = cur.waits + CNT_W'(ready_wait_pkg::ASYNC_EXTRA_WAITS);
				end
				ready_wait_pkg::ST_RDY: begin
					if (ready_is_active(cur.rdy_async ? cur.sync2 : ready_in, cur.rdy_pol)) begin
						next_cur.st = ready_wait_pkg::ST_HOLD;
					end else if (cur.waits != {CNT_W{1'b1}}) begin
						// Not ready: one more waitstate; count saturates, cycle does not
						next_cur.waits = cur.waits + CNT_ONE;
					end
				end
				ready_wait_pkg::ST_HOLD: begin
					if (cur.cnt == CNT_ZERO) begin
						next_cur.st = ready_wait_pkg::ST_IDLE;
						next_cur.busy = 1'b0;
						next_cur.done = 1'b1;
					end else begin
						next_cur.cnt = cur.cnt - CNT_ONE;
					end
				end
				default: begin
					next_cur.st = ready_wait_pkg::ST_IDLE;
				end
			endcase
			// Entering the closing phase: strobe rises, address drops, read data latched on reads only
			if (next_cur.st == ready_wait_pkg::ST_HOLD && cur.st != ready_wait_pkg::ST_HOLD) begin
				next_cur.cnt = cur.hold_len;
				next_cur.rd_n = ready_wait_pkg::STROBE_IDLE;
				next_cur.wr_n = ready_wait_pkg::STROBE_IDLE;
				next_cur.addr_v = 1'b0;
				if (!cur.is_write) begin
					next_cur.rdata = read_data_in;
				end
			end
		end
	end

	// Single state register; clock enable freezes everything including the reference clock
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			cur.st <= ready_wait_pkg::ST_IDLE;
			cur.ref_clk <= ready_wait_pkg::REF_CLK_RST;
			cur.cnt <= '0;
			cur.waits <= '0;
			cur.mand_len <= '0;
			cur.hold_len <= '0;
			cur.rdy_en <= 1'b0;
			cur.rdy_async <= 1'b0;
			cur.rdy_pol <= 1'b0;
			cur.is_write <= 1'b0;
			cur.sync1 <= ready_wait_pkg::READY_RST;
			cur.sync2 <= ready_wait_pkg::READY_RST;
			cur.rd_n <= ready_wait_pkg::STROBE_IDLE;
			cur.wr_n <= ready_wait_pkg::STROBE_IDLE;
			cur.addr_v <= 1'b0;
			cur.busy <= 1'b0;
			cur.done <= 1'b0;
			cur.rdata <= '0;
		end else if (clk_en) begin
			cur <= next_cur;
		end
	end

	assign bus_reference_clock_out = cur.ref_clk;
	assign read_strobe_n = cur.rd_n;
	assign write_strobe_n = cur.wr_n;
	assign address_valid = cur.addr_v;
	assign cycle_busy = cur.busy;
	assign cycle_done = cur.done;
	assign ready_wait_phase = cur.waits;
	assign read_data = cur.rdata;

	// Checks on the cycle sequencer
	mand_ignore_a: assert property (@(posedge sys_clk) disable iff (reset)
		(clk_en && tick && cur.st == ready_wait_pkg::ST_CMD && cur.cnt != CNT_ZERO)
		|=> (cur.st == ready_wait_pkg::ST_CMD && cur.cnt == $past(cur.cnt) - CNT_ONE))
		else $error("ready evaluated during mandatory waitstates");
	sync_notrdy_a: assert property (@(posedge sys_clk) disable iff (reset)
		(clk_en && tick && cur.st == ready_wait_pkg::ST_RDY && !cur.rdy_async
		&& !ready_is_active(ready_in, cur.rdy_pol) && cur.waits != {CNT_W{1'b1}})
		|=> (cur.st == ready_wait_pkg::ST_RDY && cur.waits == $past(cur.waits) + CNT_ONE))
		else $error("inactive ready did not insert one waitstate");
	sync_end_a: assert property (@(posedge sys_clk) disable iff (reset)
		(clk_en && tick && cur.st == ready_wait_pkg::ST_CMD && cur.cnt == CNT_ZERO && cur.rdy_en
		&& !cur.rdy_async && ready_is_active(ready_in, cur.rdy_pol))
		|=> (cur.st == ready_wait_pkg::ST_HOLD && read_strobe_n && write_strobe_n))
		else $error("synchronous ready did not end cycle without waitstate");
	async_end_a: assert property (@(posedge sys_clk) disable iff (reset)
		(clk_en && tick && cur.st == ready_wait_pkg::ST_RDY && cur.rdy_async
		&& ready_is_active(cur.sync2, cur.rdy_pol))
		|=> (cur.st == ready_wait_pkg::ST_HOLD && !address_valid))
		else $error("asynchronous ready did not end cycle");
	async_delay_a: assert property (@(posedge sys_clk) disable iff (reset)
		(clk_en && tick && cur.st == ready_wait_pkg::ST_CMD && cur.cnt == CNT_ZERO
		&& cur.rdy_en && cur.rdy_async)
		|=> (cur.st == ready_wait_pkg::ST_SYNC) ##1 (!clk_en || cur.st == ready_wait_pkg::ST_SYNC))
		else $error("asynchronous sample point not delayed");
	fixed_len_a: assert property (@(posedge sys_clk) disable iff (reset)
		(clk_en && tick && cur.st == ready_wait_pkg::ST_CMD && cur.cnt == CNT_ZERO && !cur.rdy_en)
		|=> (cur.st == ready_wait_pkg::ST_HOLD && cur.cnt == $past(cur.hold_len)))
		else $error("ready-disabled cycle did not close after waitstates");
	read_capture_a: assert property (@(posedge sys_clk) disable iff (reset)
		$rose(read_strobe_n) |-> (read_data == $past(read_data_in)))
		else $error("read data not taken on strobe rising edge");
	phase_load_a: assert property (@(posedge sys_clk) disable iff (reset)
		(clk_en && tick && cur.st == ready_wait_pkg::ST_IDLE && cycle_start)
		|=> (cur.st == ready_wait_pkg::ST_ADDR && cur.cnt == $past(addr_phase_len)
		&& cur.mand_len == $past(mandatory_wait_phase)))
		else $error("cycle phase programme not latched at start");
	polarity_a: assert property (@(posedge sys_clk) disable iff (reset)
		(clk_en && tick && cur.st == ready_wait_pkg::ST_RDY && !cur.rdy_async
		&& (ready_in != cur.rdy_pol)) |=> (cur.st == ready_wait_pkg::ST_RDY))
		else $error("ready of wrong polarity ended the cycle");
endmodule

// ### src/ready_wait_pkg.sv
package ready_wait_pkg;
	// System clock period at 50 MHz
	localparam int SYS_PERIOD_NS = 20;
	// One bus reference clock period spans this many system clocks
	localparam int BUS_CLK_DIV = 2;
	// Default data width of the read path
	localparam int DATA_W_DEF = 16;
	// Default width of phase and waitstate counters
	localparam int CNT_W_DEF = 4;
	// Extra bus clocks that the asynchronous synchroniser stage costs
	localparam int ASYNC_EXTRA_WAITS = 1;
	// Reset level of the bus reference clock output
	localparam logic REF_CLK_RST = 1'b0;
	// Inactive level of the low-active command strobes
	localparam logic STROBE_IDLE = 1'b1;
	// Ready sampled after reset: low, inactive only when ready is active-high
	localparam logic READY_RST = 1'b0;

	// Bus cycle phases
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_CMD = 3'b010,
		ST_SYNC = 3'b011,
		ST_RDY = 3'b100,
		ST_HOLD = 3'b101
	} bus_state_t;
endpackage

// ### sim/ready_responder.sv
`timescale 1ns/100ps
module ready_responder (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic bus_reference_clock_out,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic [7:0] ready_after,
	input wire logic active_high,
	input wire logic [15:0] data_value,
	output logic ready_in,
	output logic [15:0] read_data_in
);
	logic [7:0] low_ticks;
	logic [15:0] junk;
	logic ref_prev;
	wire logic strobe_on = !read_strobe_n || !write_strobe_n;
	// Bus clocks seen with a strobe low, counted just after each fall of the reference clock;
	// edge based so that a frozen reference clock is not counted twice; cleared as the strobe rises
	always_ff @(posedge sys_clk) begin
		ref_prev <= bus_reference_clock_out;
		if (reset || !strobe_on) begin
			low_ticks <= 8'h00;
		end else if (ref_prev && !bus_reference_clock_out && low_ticks != 8'hff) begin
			low_ticks <= low_ticks + 8'h01;
		end
	end
	// Filler for a released data bus, so a stale value can never pass
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			junk <= 16'h5a5a;
		end else begin
			junk <= ~junk + 16'h1234;
		end
	end
	// Ready follows the strobe: it drops at the strobe rise and never leaks into the next cycle
	// The bus clock on which the strobe fell is counted too, hence strictly greater
	assign ready_in = (strobe_on && low_ticks > ready_after) ? active_high : !active_high;
	assign read_data_in = read_strobe_n ? junk : data_value;
endmodule

// ### sim/testbench.sv
`timescale 1ns/100ps
module testbench;
	logic sys_clk, reset, clk_en, cycle_start, cycle_write, ready_enable, ready_async, active_high;
	logic ready_in, ref_clk_out, rd_n, wr_n, address_valid, cycle_busy, cycle_done, saw_rd, saw_wr;
	logic [3:0] addr_len, mand_len, hold_len, waits;
	logic [7:0] ready_after;
	logic [15:0] data_value, last_data, read_data_in, read_data;
	int n_fail, comparisons, run_len, seed_dummy, stall_cnt;
	typedef struct {int base; int n; logic async_mode; logic [15:0] data; logic wr;} note_t;
	note_t notes[$];
	note_t nt;

	ext_bus_ready_wait_control dut (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .cycle_start(cycle_start),
		.cycle_write(cycle_write), .addr_phase_len(addr_len), .mandatory_wait_phase(mand_len),
		.hold_phase_len(hold_len), .ready_enable(ready_enable), .ready_async(ready_async),
		.ready_active_high(active_high), .ready_in(ready_in), .read_data_in(read_data_in),
		.bus_reference_clock_out(ref_clk_out), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
		.address_valid(address_valid), .cycle_busy(cycle_busy), .cycle_done(cycle_done),
		.ready_wait_phase(waits), .read_data(read_data));
	ready_responder partner (.sys_clk(sys_clk), .reset(reset), .bus_reference_clock_out(ref_clk_out),
		.read_strobe_n(rd_n), .write_strobe_n(wr_n), .ready_after(ready_after), .active_high(active_high),
		.data_value(data_value), .ready_in(ready_in), .read_data_in(read_data_in));

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	// Drive one bus cycle; mode 0 sync ready, 1 async ready, 2 ready control off
	task automatic run_cycle(input int mode, input logic wr);
		int n;
		int k;
		@(negedge sys_clk);
		n = $urandom_range(3);
		addr_len = 4'($urandom_range(3));
		mand_len = 4'($urandom_range(3));
		hold_len = 4'($urandom_range(3));
		ready_enable = (mode != 2);
		ready_async = (mode == 1);
		cycle_write = wr;
		active_high = 1'($urandom_range(1));
		data_value = 16'($urandom);
		// With control off, ready is either always active or never, both must be ignored
		ready_after = (mode == 2) ? 8'($urandom_range(1) * 255) : 8'(mand_len + n);
		if (!wr) last_data = data_value;
		// Async ready counts one extra waitstate for the synchroniser stage
		notes.push_back('{addr_len + mand_len + hold_len + 3, (mode == 2) ? 0 : n + (mode == 1), mode == 1, last_data, wr});
		cycle_start = 1;
		for (k = 0; k < 50 && !cycle_busy; k++) @(negedge sys_clk);
		cycle_start = 0;
		if (k >= 50) begin
			n_fail++;
			print_verdict();
		end
		// Random one-clock freezes inside the cycle; each one stretches it by one sys_clk
		for (k = 0; k < 200 && cycle_busy; k++) begin
			clk_en = ($urandom_range(7) != 0);
			if (!clk_en) stall_cnt++;
			@(negedge sys_clk);
		end
		clk_en = 1;
		if (k >= 200) begin
			n_fail++;
			print_verdict();
		end
	endtask

	initial begin
		sys_clk = 0;
		forever #10 sys_clk = ~sys_clk;
	end

	// Measure each cycle and compare it with the oldest note when it finishes
	always @(negedge sys_clk) begin
		if (cycle_busy) run_len++;
		if (!rd_n) saw_rd = 1'b1;
		if (!wr_n) saw_wr = 1'b1;
		if (cycle_done === 1'b1 && !reset) begin
			if (notes.size() == 0) check("note", 0, 1);
			else begin
				nt = notes.pop_front();
				if (nt.async_mode) check("async_wait", waits, nt.n);
				else check("waits", waits, nt.n);
				// Async adds its sample clock on top of the counted waitstates
				check("length", run_len, 2 * (nt.base + nt.n + nt.async_mode) + stall_cnt);
				check("read_data", read_data, nt.data);
				check("closed", {rd_n, wr_n, address_valid}, 3'h6);
				check("strobe_kind", {saw_rd, saw_wr}, nt.wr ? 2'h1 : 2'h2);
			end
			run_len = 0;
			stall_cnt = 0;
			saw_rd = 1'b0;
			saw_wr = 1'b0;
		end
	end

	initial begin
		reset = 1;
		clk_en = 1;
		stall_cnt = 0;
		saw_rd = 1'b0;
		saw_wr = 1'b0;
		cycle_start = 0;
		cycle_write = 0;
		ready_enable = 0;
		ready_async = 0;
		active_high = 1;
		addr_len = 4'h0;
		mand_len = 4'h0;
		hold_len = 4'h0;
		ready_after = 8'h00;
		data_value = 16'h0000;
		last_data = 16'h0000;
		n_fail = 0;
		comparisons = 0;
		run_len = 0;
		seed_dummy = $urandom(22604);
		repeat (3) @(posedge sys_clk);
		@(negedge sys_clk);
		reset = 0;
		check("idle_strobes", {rd_n, wr_n, cycle_busy}, 3'h6);
		// Mixed modes and directions, back to back
		for (int i = 0; i < 30; i++) begin
			if (i == 15) begin
				// Reset between cycles: everything returns to idle and read data clears
				@(negedge sys_clk);
				reset = 1;
				repeat (3) @(negedge sys_clk);
				reset = 0;
				last_data = 16'h0000;
				check("reset_idle", {rd_n, wr_n, cycle_busy, address_valid, waits, read_data}, 24'hc0_0000);
			end
			run_cycle(i % 3, 1'($urandom_range(1)));
			$display("test %0d done mode %0d", i, i % 3);
		end
		repeat (4) @(negedge sys_clk);
		check("notes_left", notes.size(), 0);
		print_verdict();
	end
endmodule
